// *** rtl/srd_rx_dma.sv ***
// Functional notes
// - descriptors are 8 bytes, read strictly in sequence from the table
// - a finished descriptor with wrap set resets the selector to zero
// - completion interrupt needs descriptor request flag and control enable
// - packet data is written only as full 32-bit words
// - nothing is received until the receiver enable bit is set
// - no descriptors available and hold off: the packet is discarded
// - hold on: wait, leave characters queued so the fifo stops credits
// - enabled descriptor stores packet; disabled clears available, drops or holds
// - clearing receiver enable finishes the current packet, then accepts none
// - clearing descriptors-available spares ongoing packet, stops descriptor reads
// - on completion clear enable, write status and byte count
// - each received packet sets the packet-received status bit
// - crc runs over all bytes but end markers; byte 3 gives header length
// - nonzero crc at header end sets the header crc error flag
// - crc continues to packet end; nonzero sets data crc error flag
// - bus error: spill to end marker, disable, go idle, flag error
// - promiscuous: all data but rmap commands owned by the target goes to this channel regardless of address
// - promiscuous mode still truncates packets beyond the length limit
// - promiscuous: rmap commands go to target if enabled, else stored
// - table is 1024-byte aligned; selector steps by one and wraps
//
// Chosen here: register access over APB and the register addresses.
`timescale 1ns/1ps
module srd_rx_dma (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        rx_valid,
	input  wire logic [7:0]  rx_data,
	input  wire logic        rx_end,
	input  wire logic        rx_match,
	input  wire logic        rx_rmap_cmd,
	output logic             rx_ready,
	output logic             rx_hold,
	output logic             rmap_fwd,
	output logic             mem_req,
	output logic             mem_write,
	output logic      [31:0] mem_addr,
	output logic      [31:0] mem_wdata,
	input  wire logic [31:0] mem_rdata,
	input  wire logic        mem_ack,
	input  wire logic        mem_err,
	output logic             rx_irq
);
	import srd_pkg::*;
	typedef struct packed {
		srd_state_e            st;
		logic                  rxen;
		logic                  dav;
		logic                  hold;
		logic                  ien;
		logic                  pkt;
		logic                  aerr;
		logic                  prom;
		logic                  rmapen;
		logic [SRD_LEN_W-1:0]  maxl;
		logic [SRD_BASE_W-1:0] base;
		logic [SRD_SEL_W-1:0]  sel;
		logic                  wr;
		logic                  ie;
		logic [29:0]           ptr;
		logic [SRD_LEN_W-1:0]  cnt;
		logic [SRD_LEN_W-1:0]  pos;
		logic [7:0]            hlen;
		logic                  hknown;
		logic                  hc;
		logic                  dc;
		logic                  tr;
		logic [7:0]            crc;
		logic                  last;
		logic                  serr;
		logic                  irq;
		logic                  fwd;
		logic [31:0]           maddr;
		logic [31:0]           stw;
		logic [31:0]           rdat;
	} srd_main_s;
	srd_main_s   q_ff;
	srd_main_s   nxt_q;
	logic [7:0]  crc_nxt;
	logic [31:0] pk_word;
	logic [2:0]  pk_n;
	logic        pk_clr;
	logic        pk_push;
	logic        take;
	logic        wr_ctrl;
	logic        acc_ok;
	logic [31:0] dsc_addr;

	srd_crc u_crc (
		.crc_in  (q_ff.crc),
		.din     (rx_data),
		.crc_out (crc_nxt)
	);

	srd_pack u_pack (
		.pclk    (pclk),
		.presetn (presetn),
		.clr     (pk_clr),
		.push    (pk_push),
		.din     (rx_data),
		.word    (pk_word),
		.nbytes  (pk_n)
	);

	assign take     = rx_valid & rx_ready;
	assign wr_ctrl  = psel & penable & pwrite & (paddr[11:0] == SRD_OFF_CTRL);
	// descriptor address: aligned base plus selector times eight
	assign dsc_addr = {q_ff.base, q_ff.sel, SRD_DW0_OFS};
	// promiscuous takes all but rmap commands owned by the target
	assign acc_ok   = rx_match | (q_ff.prom & ~(rx_rmap_cmd & q_ff.rmapen));

	always_comb begin
		nxt_q    = q_ff;
		nxt_q.irq = 1'b0;
		nxt_q.fwd = 1'b0;
		rx_ready = 1'b0;
		rx_hold  = 1'b0;
		pk_clr   = 1'b0;
		pk_push  = 1'b0;

		// apb read data captured in the setup cycle
		if (psel & ~penable & ~pwrite) begin
			case (paddr[11:0])
				SRD_OFF_CTRL: begin
					nxt_q.rdat = 32'h0000_0000;
					nxt_q.rdat[SRD_CB_RXEN] = q_ff.rxen;
					nxt_q.rdat[SRD_CB_DAV]  = q_ff.dav;
					nxt_q.rdat[SRD_CB_HOLD] = q_ff.hold;
					nxt_q.rdat[SRD_CB_IEN]  = q_ff.ien;
					nxt_q.rdat[SRD_CB_PKT]  = q_ff.pkt;
					nxt_q.rdat[SRD_CB_AERR] = q_ff.aerr;
					nxt_q.rdat[SRD_CB_ACT]  = (q_ff.st != S_IDLE);
					nxt_q.rdat[SRD_CB_PROM] = q_ff.prom;
					nxt_q.rdat[SRD_CB_RMAP] = q_ff.rmapen;
				end
				SRD_OFF_MAXL: begin
					nxt_q.rdat = {7'h00, q_ff.maxl};
				end
				SRD_OFF_DESC: begin
					nxt_q.rdat = dsc_addr;
				end
				default: begin
					nxt_q.rdat = 32'h0000_0000;
				end
			endcase
		end

		// apb writes; status bits are write-one-to-clear
		if (psel & penable & pwrite) begin
			case (paddr[11:0])
				SRD_OFF_CTRL: begin
					nxt_q.rxen   = pwdata[SRD_CB_RXEN];
					nxt_q.hold   = pwdata[SRD_CB_HOLD];
					nxt_q.ien    = pwdata[SRD_CB_IEN];
					nxt_q.prom   = pwdata[SRD_CB_PROM];
					nxt_q.rmapen = pwdata[SRD_CB_RMAP];
					if (pwdata[SRD_CB_PKT]) begin
						nxt_q.pkt = 1'b0;
					end
					if (pwdata[SRD_CB_AERR]) begin
						nxt_q.aerr = 1'b0;
					end
					if (!pwdata[SRD_CB_DAV]) begin
						nxt_q.dav = 1'b0;
					end
				end
				SRD_OFF_MAXL: begin
					nxt_q.maxl = {pwdata[SRD_LEN_W-1:2], 2'b00};
				end
				SRD_OFF_DESC: begin
					nxt_q.base = pwdata[31:10];
					nxt_q.sel  = pwdata[9:3];
				end
				default: begin
				end
			endcase
		end

		case (q_ff.st)
			S_IDLE: begin
				if (rx_valid) begin
					if (rx_end) begin
						rx_ready = 1'b1;
					end else if (!q_ff.rxen || !acc_ok) begin
						nxt_q.fwd  = rx_rmap_cmd & q_ff.rmapen;
						nxt_q.serr = 1'b0;
						nxt_q.st   = S_SPILL;
					end else if (!q_ff.dav) begin
						if (q_ff.hold) begin
							rx_hold = 1'b1;
						end else begin
							nxt_q.serr = 1'b0;
							nxt_q.st   = S_SPILL;
						end
					end else begin
						nxt_q.maddr = dsc_addr;
						nxt_q.st    = S_DRD0;
					end
				end
			end
			S_DRD0: begin
				if (mem_err) begin
					nxt_q.serr = 1'b1;
					nxt_q.st   = S_SPILL;
				end else if (mem_ack) begin
					if (mem_rdata[SRD_DW0_EN]) begin
						nxt_q.wr    = mem_rdata[SRD_DW0_WR];
						nxt_q.ie    = mem_rdata[SRD_DW0_IE];
						nxt_q.maddr = {q_ff.base, q_ff.sel, SRD_DW1_OFS};
						nxt_q.st    = S_DRD1;
					end else begin
						nxt_q.dav = 1'b0;
						if (q_ff.hold) begin
							nxt_q.st = S_IDLE;
						end else begin
							nxt_q.serr = 1'b0;
							nxt_q.st   = S_SPILL;
						end
					end
				end
			end
			S_DRD1: begin
				if (mem_err) begin
					nxt_q.serr = 1'b1;
					nxt_q.st   = S_SPILL;
				end else if (mem_ack) begin
					nxt_q.ptr    = mem_rdata[31:2];
					nxt_q.cnt    = '0;
					nxt_q.pos    = '0;
					nxt_q.hknown = 1'b0;
					nxt_q.hc     = 1'b0;
					nxt_q.dc     = 1'b0;
					nxt_q.tr     = 1'b0;
					nxt_q.crc    = SRD_RST_CRC;
					nxt_q.last   = 1'b0;
					pk_clr       = 1'b1;
					nxt_q.st     = S_RECV;
				end
			end
			S_RECV: begin
				rx_ready = 1'b1;
				if (rx_valid && rx_end) begin
					nxt_q.dc = (q_ff.crc != 8'h00);
					if (pk_n != 3'h0) begin
						nxt_q.last  = 1'b1;
						nxt_q.maddr = {q_ff.ptr, 2'b00};
						nxt_q.st    = S_WRW;
					end else begin
						nxt_q.st = S_STAT;
					end
				end else if (rx_valid) begin
					nxt_q.crc = crc_nxt;
					nxt_q.pos = q_ff.pos + 25'h000_0001;
					if (q_ff.pos == SRD_CMD_IDX) begin
						nxt_q.hknown = 1'b1;
						if (rx_data[6]) begin
							nxt_q.hlen = SRD_HDR_CMD + {4'h0, rx_data[1:0], 2'b00};
						end else if (rx_data[5]) begin
							nxt_q.hlen = SRD_HDR_WREP;
						end else begin
							nxt_q.hlen = SRD_HDR_RREP;
						end
					end
					if (q_ff.hknown && (nxt_q.pos == {17'h0_0000, q_ff.hlen})) begin
						nxt_q.hc = (crc_nxt != 8'h00);
					end
					if (q_ff.cnt >= q_ff.maxl) begin
						nxt_q.tr = 1'b1;
					end else begin
						pk_push   = 1'b1;
						nxt_q.cnt = q_ff.cnt + 25'h000_0001;
						if (pk_n == 3'h3) begin
							nxt_q.maddr = {q_ff.ptr, 2'b00};
							nxt_q.st    = S_WRW;
						end
					end
				end
			end
			S_WRW: begin
				if (mem_err) begin
					pk_clr = 1'b1;
					if (q_ff.last) begin
						nxt_q.rxen = 1'b0;
						nxt_q.aerr = 1'b1;
						nxt_q.st   = S_IDLE;
					end else begin
						nxt_q.serr = 1'b1;
						nxt_q.st   = S_SPILL;
					end
				end else if (mem_ack) begin
					pk_clr    = 1'b1;
					nxt_q.ptr = q_ff.ptr + 30'h0000_0001;
					if (q_ff.last) begin
						nxt_q.st = S_STAT;
					end else begin
						nxt_q.st = S_RECV;
					end
				end
			end
			S_STAT: begin
				if (mem_err) begin
					nxt_q.rxen = 1'b0;
					nxt_q.aerr = 1'b1;
					nxt_q.st   = S_IDLE;
				end else if (mem_ack) begin
					if (q_ff.wr) begin
						nxt_q.sel = SRD_RST_SEL;
					end else begin
						nxt_q.sel = q_ff.sel + 7'h01;
					end
					nxt_q.pkt = 1'b1;
					nxt_q.irq = q_ff.ie & q_ff.ien;
					nxt_q.st  = S_IDLE;
				end
			end
			S_SPILL: begin
				rx_ready = 1'b1;
				if (rx_valid && rx_end) begin
					if (q_ff.serr) begin
						nxt_q.rxen = 1'b0;
						nxt_q.aerr = 1'b1;
					end
					nxt_q.st = S_IDLE;
				end
			end
			default: begin
				nxt_q.st = S_IDLE;
			end
		endcase

		// status word: enable cleared, flags and byte count
		if (q_ff.st != S_STAT) begin
			nxt_q.stw = 32'h0000_0000;
			nxt_q.stw[SRD_LEN_W-1:0] = nxt_q.cnt;
			nxt_q.stw[SRD_DW0_WR] = q_ff.wr;
			nxt_q.stw[SRD_DW0_IE] = q_ff.ie;
			nxt_q.stw[SRD_DW0_HC] = nxt_q.hc;
			nxt_q.stw[SRD_DW0_DC] = nxt_q.dc;
			nxt_q.stw[SRD_DW0_TR] = nxt_q.tr;
			if (nxt_q.st == S_STAT) begin
				nxt_q.maddr = dsc_addr;
			end
		end

		// a software set of descriptors-available wins
		if (wr_ctrl && pwdata[SRD_CB_DAV]) begin
			nxt_q.dav = 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q_ff      <= '0;
			q_ff.st   <= S_IDLE;
			q_ff.maxl <= SRD_RST_MAXL;
			q_ff.base <= SRD_RST_BASE;
			q_ff.sel  <= SRD_RST_SEL;
			q_ff.crc  <= SRD_RST_CRC;
		end else begin
			q_ff <= nxt_q;
		end
	end

	assign prdata    = q_ff.rdat;
	assign pready    = 1'b1;
	assign pslverr   = psel & penable & (paddr[11:0] != SRD_OFF_CTRL)
		& (paddr[11:0] != SRD_OFF_MAXL) & (paddr[11:0] != SRD_OFF_DESC);
	assign mem_req   = (q_ff.st == S_DRD0) | (q_ff.st == S_DRD1)
		| (q_ff.st == S_WRW) | (q_ff.st == S_STAT);
	assign mem_write = (q_ff.st == S_WRW) | (q_ff.st == S_STAT);
	assign mem_addr  = q_ff.maddr;
	// whole words only, last partial word padded with zeros
	assign mem_wdata = (q_ff.st == S_STAT) ? q_ff.stw : pk_word;
	assign rx_irq    = q_ff.irq;
	assign rmap_fwd  = q_ff.fwd;
endmodule

// *** rtl/srd_pkg.sv ***
package srd_pkg;
	// register byte offsets
	localparam logic [11:0] SRD_OFF_CTRL = 12'h000;
	localparam logic [11:0] SRD_OFF_MAXL = 12'h004;
	localparam logic [11:0] SRD_OFF_DESC = 12'h008;
	// control register bit positions
	localparam int SRD_CB_RXEN = 0;
	localparam int SRD_CB_DAV  = 1;
	localparam int SRD_CB_HOLD = 2;
	localparam int SRD_CB_IEN  = 3;
	localparam int SRD_CB_PKT  = 4;
	localparam int SRD_CB_AERR = 5;
	localparam int SRD_CB_ACT  = 6;
	localparam int SRD_CB_PROM = 7;
	localparam int SRD_CB_RMAP = 8;
	// descriptor word 0 fields
	localparam int SRD_LEN_W  = 25;
	localparam int SRD_DW0_EN = 25;
	localparam int SRD_DW0_WR = 26;
	localparam int SRD_DW0_IE = 27;
	localparam int SRD_DW0_HC = 28;
	localparam int SRD_DW0_DC = 29;
	localparam int SRD_DW0_TR = 30;
	// descriptor table geometry
	localparam int SRD_SEL_W  = 7;
	localparam int SRD_BASE_W = 22;
	localparam logic [2:0] SRD_DW0_OFS = 3'h0;
	localparam logic [2:0] SRD_DW1_OFS = 3'h4;
	// values after reset
	localparam logic [SRD_LEN_W-1:0]  SRD_RST_MAXL = 25'h000_0000;
	localparam logic [SRD_BASE_W-1:0] SRD_RST_BASE = 22'h00_0000;
	localparam logic [SRD_SEL_W-1:0]  SRD_RST_SEL  = 7'h00;
	localparam logic [7:0]            SRD_RST_CRC  = 8'h00;
	// header length decode and crc polynomial
	localparam logic [SRD_LEN_W-1:0] SRD_CMD_IDX  = 25'h000_0003;
	localparam logic [7:0]           SRD_HDR_CMD  = 8'h10;
	localparam logic [7:0]           SRD_HDR_WREP = 8'h08;
	localparam logic [7:0]           SRD_HDR_RREP = 8'h0c;
	localparam logic [7:0]           SRD_CRC_POLY = 8'h07;
	typedef enum logic [2:0] {
		S_IDLE,
		S_DRD0,
		S_DRD1,
		S_RECV,
		S_WRW,
		S_STAT,
		S_SPILL
	} srd_state_e;
endpackage

// *** rtl/srd_crc.sv ***
`timescale 1ns/1ps
module srd_crc (
	input  wire logic [7:0] crc_in,
	input  wire logic [7:0] din,
	output logic      [7:0] crc_out
);
	import srd_pkg::*;
	always_comb begin
		logic [7:0] c;
		c = crc_in;
		// bit-serial crc-8, data lsb first
		for (int i = 0; i < 8; i++) begin
			if (c[7] ^ din[i]) begin
				c = {c[6:0], 1'b0} ^ SRD_CRC_POLY;
			end else begin
				c = {c[6:0], 1'b0};
			end
		end
		crc_out = c;
	end
endmodule

// *** rtl/srd_pack.sv ***
`timescale 1ns/1ps
module srd_pack (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        clr,
	input  wire logic        push,
	input  wire logic [7:0]  din,
	output logic      [31:0] word,
	output logic      [2:0]  nbytes
);
	import srd_pkg::*;
	typedef struct packed {
		logic [31:0] w;
		logic [2:0]  n;
	} srd_pack_s;
	srd_pack_s q_ff;
	srd_pack_s nxt_q;
	// first byte lands in the top lane
	always_comb begin
		nxt_q = q_ff;
		if (clr) begin
			nxt_q.w = 32'h0000_0000;
			nxt_q.n = 3'h0;
		end else if (push) begin
			nxt_q.w[31 - 8 * q_ff.n[1:0] -: 8] = din;
			nxt_q.n = q_ff.n + 3'h1;
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q_ff <= '0;
		end else begin
			q_ff <= nxt_q;
		end
	end
	assign word   = q_ff.w;
	assign nbytes = q_ff.n;
endmodule

// *** test/srd_rx_dma_properties.sv ***
`timescale 1ns/1ps
module srd_rx_dma_properties
	import srd_pkg::*;
(
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic        rx_ready,
	input wire logic        rx_hold,
	input wire logic        rmap_fwd,
	input wire logic        mem_req,
	input wire logic        mem_write,
	input wire logic [31:0] mem_addr,
	input wire logic [31:0] mem_wdata,
	input wire logic        mem_ack,
	input wire logic        mem_err,
	input wire logic        rx_irq
);
	logic        ien_ff, hold_ff, rmap_ff, seen_ff, err_ff;
	logic [31:0] d0_ff;
	wire         ctrl_wr = psel & penable & pwrite & (paddr[11:0] == SRD_OFF_CTRL);
	// shadow of software control writes, bus errors and descriptor word 0 reads
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ien_ff <= 1'b0;
			hold_ff <= 1'b0;
			rmap_ff <= 1'b0;
			seen_ff <= 1'b0;
			err_ff <= 1'b0;
			d0_ff <= 32'h0000_0000;
		end else begin
			if (ctrl_wr) begin
				ien_ff <= pwdata[SRD_CB_IEN];
				hold_ff <= pwdata[SRD_CB_HOLD];
				rmap_ff <= pwdata[SRD_CB_RMAP];
				seen_ff <= seen_ff | pwdata[SRD_CB_RXEN];
			end
			if (mem_err)
				err_ff <= 1'b1;
			else if (ctrl_wr && pwdata[SRD_CB_RXEN])
				err_ff <= 1'b0;
			if (mem_req && mem_ack && !mem_write && !mem_addr[2])
				d0_ff <= mem_addr;
		end
	end
	default clocking @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	req_hold_a: assert property (
		mem_req && !mem_ack && !mem_err |=>
		mem_req && $stable(mem_addr) && $stable(mem_write) && $stable(mem_wdata))
		else $error("memory request changed early");
	word_align_a: assert property (mem_req |-> mem_addr[1:0] == 2'b00)
		else $error("unaligned memory access");
	busy_ready_a: assert property (mem_req |-> !rx_ready)
		else $error("stream taken during memory access");
	rxen_gate_a: assert property (mem_req |-> seen_ff)
		else $error("memory access before receiver enable");
	irq_gate_a: assert property (rx_irq |-> ien_ff ##1 !rx_irq)
		else $error("bad completion interrupt");
	hold_stall_a: assert property (rx_hold |-> hold_ff && !rx_ready)
		else $error("hold without stall");
	rmap_gate_a: assert property (rmap_fwd |-> rmap_ff ##1 !rmap_fwd)
		else $error("bad command forward");
	err_stop_a: assert property (err_ff |-> !mem_req)
		else $error("memory access after bus error");
	status_clr_a: assert property (
		mem_req && mem_write && mem_addr == d0_ff |-> !mem_wdata[SRD_DW0_EN])
		else $error("status left descriptor enabled");
	cover property (rx_irq);
	cover property (rx_hold ##1 !rx_hold);
	cover property (mem_req && mem_err);
endmodule

// *** test/srd_mem_model.sv ***
`timescale 1ns/1ps
module srd_mem_model (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        mem_req,
	input  wire logic        mem_write,
	input  wire logic [31:0] mem_addr,
	input  wire logic [31:0] mem_wdata,
	output logic      [31:0] mem_rdata,
	output logic             mem_ack,
	output logic             mem_err,
	input  wire logic [3:0]  dly,
	input  wire logic        err_on,
	input  wire logic [31:0] err_addr
);
	logic [31:0] mem [0:511];
	logic [3:0]  cnt_ff;
	wire         hit = err_on && (mem_addr == err_addr);
	// answers after dly waits; read data toggles when not valid
	// plain always: the bench also preloads the array
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mem_ack <= 1'b0;
			mem_err <= 1'b0;
			cnt_ff <= 4'h0;
			mem_rdata <= 32'h5a5a_5a5a;
		end else begin
			mem_ack <= 1'b0;
			mem_err <= 1'b0;
			mem_rdata <= ~mem_rdata;
			if (mem_req && !mem_ack && !mem_err) begin
				cnt_ff <= cnt_ff + 4'h1;
				if (cnt_ff >= dly) begin
					cnt_ff <= 4'h0;
					mem_ack <= !hit;
					mem_err <= hit;
					if (mem_write && !hit)
						mem[mem_addr[10:2]] <= mem_wdata;
					else
						mem_rdata <= mem[mem_addr[10:2]];
				end
			end
		end
	end
endmodule

// *** test/tb_spacewire_rx_dma_channel.sv ***
`timescale 1ns/1ps
`define CK(n, e, g) begin compares++; if ((g) !== (e)) begin error_cnt++; \
	$display("[FAIL] %s exp %h got %h", n, e, g); end end
module tb_spacewire_rx_dma_channel;
	import srd_pkg::*;
	localparam logic [31:0] C_EN = 32'h1 << SRD_CB_RXEN;
	localparam logic [31:0] C_DV = 32'h1 << SRD_CB_DAV;
	localparam logic [31:0] C_HD = 32'h1 << SRD_CB_HOLD;
	localparam logic [31:0] C_IE = 32'h1 << SRD_CB_IEN;
	localparam logic [31:0] C_PK = 32'h1 << SRD_CB_PKT;
	localparam logic [31:0] C_AE = 32'h1 << SRD_CB_AERR;
	localparam logic [31:0] C_PM = 32'h1 << SRD_CB_PROM;
	localparam logic [31:0] C_RM = 32'h1 << SRD_CB_RMAP;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, slv, err_on;
	logic        rx_valid, rx_end, rx_match, rx_rmap_cmd, rx_ready, rx_hold, rmap_fwd;
	logic        mem_req, mem_write, mem_ack, mem_err, rx_irq;
	logic [31:0] paddr, pwdata, prdata, mem_addr, mem_wdata, mem_rdata, err_addr, q;
	logic [7:0]  rx_data;
	logic [3:0]  dly;
	int          error_cnt, compares, irqs, fwds;
	srd_rx_dma i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .rx_valid(rx_valid), .rx_data(rx_data), .rx_end(rx_end),
		.rx_match(rx_match), .rx_rmap_cmd(rx_rmap_cmd), .rx_ready(rx_ready),
		.rx_hold(rx_hold), .rmap_fwd(rmap_fwd), .mem_req(mem_req), .mem_write(mem_write),
		.mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
		.mem_ack(mem_ack), .mem_err(mem_err), .rx_irq(rx_irq));
	srd_mem_model i_mem (.pclk(pclk), .presetn(presetn), .mem_req(mem_req),
		.mem_write(mem_write), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
		.mem_rdata(mem_rdata), .mem_ack(mem_ack), .mem_err(mem_err), .dly(dly),
		.err_on(err_on), .err_addr(err_addr));
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	always @(negedge pclk) begin
		irqs += (rx_irq === 1'b1);
		fwds += (rmap_fwd === 1'b1);
	end
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= {20'h0_0000, a};
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		q = prdata;
		slv = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic snd(input int n, input int p, input logic [7:0] v, input logic m, input logic r);
		for (int i = 0; i <= n; i++) begin
			rx_valid <= 1'b1;
			rx_data <= (i == p) ? v : 8'h00;
			rx_end <= (i == n);
			rx_match <= m;
			rx_rmap_cmd <= r;
			do @(negedge pclk); while (rx_ready !== 1'b1);
			@(posedge pclk);
		end
		rx_valid <= 1'b0;
		rx_data <= 8'hff;
		@(posedge pclk);
	endtask
	task automatic dsc(input int k, input logic [31:0] b, input logic wr, input logic ie);
		i_mem.mem[257 + 2 * k] = b;
		i_mem.mem[256 + 2 * k] = (32'h1 << SRD_DW0_EN) | (32'(wr) << SRD_DW0_WR) |
			(32'(ie) << SRD_DW0_IE);
	endtask
	task automatic fin();
		for (int i = 0; i < 40; i++) begin
			apb(1'b0, SRD_OFF_CTRL, 32'h0);
			if (q[SRD_CB_ACT] !== 1'b1) break;
		end
	endtask
	task automatic chk(input int k, input int n, input logic hc, input logic dc, input logic tr);
		fin();
		q = i_mem.mem[256 + 2 * k];
		`CK("length", n[24:0], q[24:0])
		`CK("enable", 1'b0, q[SRD_DW0_EN])
		`CK("hdr crc", hc, q[SRD_DW0_HC])
		`CK("data crc", dc, q[SRD_DW0_DC])
		`CK("trunc", tr, q[SRD_DW0_TR])
	endtask
	task automatic stop_test();
		$display("mismatches %0d of %0d compares", error_cnt, compares);
		if (error_cnt == 0 && compares > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge pclk);
		error_cnt++;
		stop_test();
	end
	initial begin
		presetn = 1'b0;
		{psel, penable, pwrite, paddr, pwdata, err_on, err_addr, dly} = '0;
		{rx_valid, rx_data, rx_end, rx_match, rx_rmap_cmd} = '0;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(1'b0, SRD_OFF_CTRL, 32'h0);
		`CK("ctrl rst", 32'h0, q)
		apb(1'b0, 12'hffc, 32'h0);
		`CK("unmapped", 1'b1, slv)
		for (int i = 384; i < 400; i++) i_mem.mem[i] = 32'hffff_ffff;
		for (int k = 0; k < 4; k++) dsc(k, 32'h0000_0600 + 32'(k) * 32'h40, k == 3, k != 1);
		apb(1'b1, SRD_OFF_MAXL, 32'h10);
		apb(1'b1, SRD_OFF_DESC, 32'h0000_0400);
		apb(1'b1, SRD_OFF_CTRL, C_EN | C_DV | C_IE);
		snd(6, 5, 8'h5a, 1'b1, 1'b0);
		chk(0, 6, 1'b0, 1'b1, 1'b0);
		`CK("word0", 32'h0, i_mem.mem[384])
		`CK("word1", 32'h005a_0000, i_mem.mem[385])
		`CK("word2", 32'hffff_ffff, i_mem.mem[386])
		apb(1'b0, SRD_OFF_CTRL, 32'h0);
		`CK("pkt bit", 1'b1, q[SRD_CB_PKT])
		apb(1'b0, SRD_OFF_DESC, 32'h0);
		`CK("desc ptr", 32'h0000_0408, q)
		apb(1'b1, SRD_OFF_CTRL, C_EN | C_DV | C_PK);
		dly <= 4'h3;
		snd(13, 0, 8'h33, 1'b1, 1'b0);
		chk(1, 13, 1'b1, 1'b1, 1'b0);
		snd(12, 0, 8'h00, 1'b1, 1'b0);
		chk(2, 12, 1'b0, 1'b0, 1'b0);
		snd(20, 0, 8'h00, 1'b1, 1'b0);
		chk(3, 16, 1'b0, 1'b0, 1'b1);
		`CK("irqs", 1, irqs)
		apb(1'b0, SRD_OFF_DESC, 32'h0);
		`CK("wrap ptr", 32'h0000_0400, q)
		dly <= 4'h0;
		snd(4, 9, 8'h00, 1'b1, 1'b0);
		apb(1'b0, SRD_OFF_CTRL, 32'h0);
		`CK("dav clr", 1'b0, q[SRD_CB_DAV])
		dsc(0, 32'h0000_0600, 1'b0, 1'b0);
		snd(4, 9, 8'h00, 1'b1, 1'b0);
		apb(1'b0, SRD_OFF_DESC, 32'h0);
		`CK("drop ptr", 32'h0000_0400, q)
		apb(1'b1, SRD_OFF_CTRL, C_EN | C_HD);
		fork
			snd(6, 1, 8'h07, 1'b1, 1'b0);
			begin
				repeat (20) @(negedge pclk);
				`CK("hold", 1'b1, rx_hold)
				`CK("stall", 1'b0, rx_ready)
				dsc(0, 32'h0000_0600, 1'b0, 1'b0);
				@(posedge pclk);
				apb(1'b1, SRD_OFF_CTRL, C_EN | C_HD | C_DV);
			end
		join
		chk(0, 6, 1'b0, 1'b1, 1'b0);
		dsc(1, 32'h0000_0640, 1'b0, 1'b0);
		err_addr <= 32'h0000_0640;
		err_on <= 1'b1;
		snd(8, 9, 8'h00, 1'b1, 1'b0);
		fin();
		`CK("aerr", 1'b1, q[SRD_CB_AERR])
		`CK("rxen off", 1'b0, q[SRD_CB_RXEN])
		err_on <= 1'b0;
		snd(4, 9, 8'h00, 1'b1, 1'b0);
		`CK("unused", 1'b1, i_mem.mem[258][SRD_DW0_EN])
		apb(1'b1, SRD_OFF_CTRL, C_EN | C_DV | C_PM | C_AE);
		snd(6, 9, 8'h00, 1'b0, 1'b0);
		chk(1, 6, 1'b0, 1'b0, 1'b0);
		apb(1'b1, SRD_OFF_CTRL, C_EN | C_DV | C_PM | C_RM);
		snd(4, 9, 8'h00, 1'b0, 1'b1);
		fin();
		`CK("forward", 1, fwds)
		dsc(2, 32'h0000_0680, 1'b0, 1'b0);
		fork
			snd(8, 9, 8'h00, 1'b1, 1'b0);
			begin
				@(posedge pclk iff (mem_req && mem_write));
				apb(1'b1, SRD_OFF_CTRL, C_DV);
			end
		join
		chk(2, 8, 1'b0, 1'b0, 1'b0);
		snd(4, 9, 8'h00, 1'b1, 1'b0);
		apb(1'b0, SRD_OFF_CTRL, 32'h0);
		`CK("no accept", 1'b1, q[SRD_CB_DAV])
		stop_test();
	end
endmodule
bind srd_rx_dma srd_rx_dma_properties i_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .rx_ready(rx_ready),
	.rx_hold(rx_hold), .rmap_fwd(rmap_fwd), .mem_req(mem_req), .mem_write(mem_write),
	.mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_err(mem_err),
	.rx_irq(rx_irq));
